/* File: src/lpbi_pkg.sv */
// Purpose: Shared constants and types for the LED PWM blink intensity block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Register index times four gives the byte address
package lpbi_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int LPBI_NUM_OUT = 17;
  localparam int LPBI_NUM_PAIR = 8;
  localparam int LPBI_AW = 8;

  // ----------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [5:0] LPBI_IDX_PHASE0 = 6'h02;
  localparam logic [5:0] LPBI_IDX_PHASE1 = 6'h03;
  localparam logic [5:0] LPBI_IDX_LEVEL = 6'h0e;
  localparam logic [5:0] LPBI_IDX_CONFIG = 6'h0f;
  localparam logic [5:0] LPBI_IDX_INTEN0 = 6'h10;
  localparam logic [5:0] LPBI_IDX_INTEN7 = 6'h17;
  localparam logic [5:0] LPBI_IDX_STATUS = 6'h1f;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int LPBI_MASTER_LSB = 4;
  localparam int LPBI_CFG_GLOBAL_BIT = 0;
  localparam logic [7:0] LPBI_LEVEL_RST = 8'h00;
  localparam logic [7:0] LPBI_INTEN_RST = 8'h00;
  localparam logic [16:0] LPBI_PHASE_RST = 17'h00000;
  localparam logic [3:0] LPBI_STATIC_SETTING = 4'hf;
  localparam logic [3:0] LPBI_MASTER_OFF = 4'h0;

  // ----------------------------------------
  // Timeslot counting
  // ----------------------------------------
  localparam logic [3:0] LPBI_SLOT_LAST = 4'hf;
  localparam logic [3:0] LPBI_SUB_LAST = 4'he;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] LPBI_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPBI_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LPBI_WR_IDLE = 2'b01,
    LPBI_WR_RESP = 2'b10
  } lpbi_wr_state_type;

  typedef enum logic [1:0] {
    LPBI_RD_IDLE = 2'b01,
    LPBI_RD_DATA = 2'b10
  } lpbi_rd_state_type;

  typedef struct packed {
    logic [3:0] slot;
    logic [3:0] sub;
  } lpbi_tick_type;

  typedef struct packed {
    logic [3:0] master;
    logic [3:0] aux;
    logic global_en;
  } lpbi_level_type;

endpackage

/* File: src/lpbi_slot_gen.sv */
// Purpose: Internal oscillator giving timeslot and sub-slot counts
// Assumes: Runs on the core clock, one sub-slot per cycle
// Notes:   Fifteen sub-slots per timeslot, sixteen timeslots per period
`timescale 1ns/1ps
`default_nettype none
module lpbi_slot_gen
  import lpbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output lpbi_pkg::lpbi_tick_type tick_o
);

  logic [3:0] slot_ff;
  logic [3:0] sub_ff;
  logic [3:0] nxt_slot;
  logic [3:0] nxt_sub;
  wire sub_wrap = (sub_ff == LPBI_SUB_LAST);

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  // Held at zero while stopped so a restart begins a clean period
  assign nxt_sub = !run_i ? 4'h0 : (sub_wrap ? 4'h0 : sub_ff + 4'h1);
  assign nxt_slot = !run_i ? 4'h0 :
                    (sub_wrap ? ((slot_ff == LPBI_SLOT_LAST) ? 4'h0 : slot_ff + 4'h1)
                              : slot_ff);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_ff <= 4'h0;
      sub_ff <= 4'h0;
    end else begin
      slot_ff <= nxt_slot;
      sub_ff <= nxt_sub;
    end
  end

  assign tick_o = '{slot: slot_ff, sub: sub_ff};

endmodule
`default_nettype wire

/* File: src/lpbi_top.sv */
// Purpose: PWM intensity and blink output stage with AXI4-Lite registers
// Assumes: Blink phase comes from an outside timer on a pin
// Notes:   Outputs are open drain; enable low means the pin is pulled low
`timescale 1ns/1ps
`default_nettype none
module lpbi_top
  import lpbi_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic BLINK_PHASE_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [lpbi_pkg::LPBI_AW-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [lpbi_pkg::LPBI_AW-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic [lpbi_pkg::LPBI_NUM_OUT-1:0] PORT_OUT_O,
  output logic [lpbi_pkg::LPBI_NUM_OUT-1:0] PORT_OE_N_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Intensity pair registers sit in one aligned block of eight
  function automatic logic is_inten_idx(input logic [5:0] idx);
    return (idx >= LPBI_IDX_INTEN0) && (idx <= LPBI_IDX_INTEN7);
  endfunction

  // Odd outputs use the upper nibble of their pair register
  function automatic logic [3:0] pick_nibble(input logic [7:0] pair, input logic upper);
    return upper ? pair[7:4] : pair[3:0];
  endfunction

  // Pull-low decision for one output in the current sub-slot
  function automatic logic drive_low(input logic [3:0] n, input logic ph_bit,
                                     input lpbi_tick_type tk, input logic [3:0] m,
                                     input logic run);
    logic in_time;
    in_time = ph_bit ? (tk.slot > n) : (tk.slot <= n);
    if (n == LPBI_STATIC_SETTING) begin
      return !ph_bit;
    end else if (!run) begin
      return 1'b0;
    end
    return in_time && (tk.sub < m);
  endfunction

  // ----------------------------------------
  // Blink phase synchroniser
  // ----------------------------------------
  logic blink_meta_ff;
  logic blink_sync_ff;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      blink_meta_ff <= 1'b0;
      blink_sync_ff <= 1'b0;
    end else begin
      blink_meta_ff <= BLINK_PHASE_I;
      blink_sync_ff <= blink_meta_ff;
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] level_ff;
  logic cfg_global_ff;
  logic [16:0] phase0_ff;
  logic [16:0] phase1_ff;
  logic [7:0] inten_ff [LPBI_NUM_PAIR];
  lpbi_level_type lvl;
  lpbi_tick_type tick;
  wire osc_run = (lvl.master != LPBI_MASTER_OFF);

  assign lvl = '{master: level_ff[LPBI_MASTER_LSB +: 4], aux: level_ff[3:0],
                 global_en: cfg_global_ff};

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  lpbi_wr_state_type wr_state_ff;
  lpbi_wr_state_type nxt_wr_state;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [5:0] wr_idx_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;

  wire wr_idle = (wr_state_ff == LPBI_WR_IDLE);
  wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire wr_go = wr_idle && aw_hold_ff && w_hold_ff;
  wire wr_level = wr_go && (wr_idx_ff == LPBI_IDX_LEVEL);
  wire wr_cfg = wr_go && (wr_idx_ff == LPBI_IDX_CONFIG);
  wire wr_ph0 = wr_go && (wr_idx_ff == LPBI_IDX_PHASE0);
  wire wr_ph1 = wr_go && (wr_idx_ff == LPBI_IDX_PHASE1);
  wire wr_inten = wr_go && is_inten_idx(wr_idx_ff);
  wire [2:0] wr_pair = wr_idx_ff[2:0];
  wire wr_mapped = wr_level || wr_cfg || wr_ph0 || wr_ph1 || wr_inten;

  wire [31:0] wr_merge_level = apply_strb({24'h0, level_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_merge_cfg = apply_strb({31'h0, cfg_global_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_merge_ph0 = apply_strb({15'h0, phase0_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_merge_ph1 = apply_strb({15'h0, phase1_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_merge_int = apply_strb({24'h0, inten_ff[wr_pair]}, wdata_ff, wstrb_ff);

  assign S_AXI_AWREADY_O = wr_idle && !aw_hold_ff;
  assign S_AXI_WREADY_O = wr_idle && !w_hold_ff;
  assign S_AXI_BVALID_O = (wr_state_ff == LPBI_WR_RESP);
  assign S_AXI_BRESP_O = bresp_ff;
  assign nxt_wr_state = wr_go ? LPBI_WR_RESP :
                        ((S_AXI_BVALID_O && S_AXI_BREADY_I) ? LPBI_WR_IDLE : wr_state_ff);

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_state_ff <= LPBI_WR_IDLE;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      wr_idx_ff <= 6'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bresp_ff <= LPBI_RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      aw_hold_ff <= wr_go ? 1'b0 : (aw_hold_ff || aw_take);
      w_hold_ff <= wr_go ? 1'b0 : (w_hold_ff || w_take);
      if (aw_take) begin
        wr_idx_ff <= S_AXI_AWADDR_I[LPBI_AW-1:2];
      end
      if (w_take) begin
        wdata_ff <= S_AXI_WDATA_I;
        wstrb_ff <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        bresp_ff <= wr_mapped ? LPBI_RESP_OKAY : LPBI_RESP_SLVERR;
      end
    end
  end

  // Both fields kept exactly as written
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      level_ff <= LPBI_LEVEL_RST;
      cfg_global_ff <= 1'b0;
      phase0_ff <= LPBI_PHASE_RST;
      phase1_ff <= LPBI_PHASE_RST;
    end else begin
      if (wr_level) begin
        level_ff <= wr_merge_level[7:0];
      end
      if (wr_cfg) begin
        cfg_global_ff <= wr_merge_cfg[LPBI_CFG_GLOBAL_BIT];
      end
      if (wr_ph0) begin
        phase0_ff <= wr_merge_ph0[16:0];
      end
      if (wr_ph1) begin
        phase1_ff <= wr_merge_ph1[16:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int p = 0; p < LPBI_NUM_PAIR; p++) begin
        inten_ff[p] <= LPBI_INTEN_RST;
      end
    end else if (wr_inten) begin
      inten_ff[wr_pair] <= wr_merge_int[7:0];
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  lpbi_rd_state_type rd_state_ff;
  lpbi_rd_state_type nxt_rd_state;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_mux;
  logic rd_hit;

  wire rd_idle = (rd_state_ff == LPBI_RD_IDLE);
  wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire [5:0] rd_idx = S_AXI_ARADDR_I[LPBI_AW-1:2];
  wire rd_is_inten = is_inten_idx(rd_idx);
  // Status: live blink phase, oscillator state and current timeslot
  wire [31:0] status_word = {25'h0, blink_sync_ff, osc_run, 1'b0, tick.slot};

  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    if (rd_idx == LPBI_IDX_LEVEL) begin
      rd_mux = {24'h0, level_ff};
    end else if (rd_idx == LPBI_IDX_CONFIG) begin
      rd_mux = {31'h0, cfg_global_ff};
    end else if (rd_idx == LPBI_IDX_PHASE0) begin
      rd_mux = {15'h0, phase0_ff};
    end else if (rd_idx == LPBI_IDX_PHASE1) begin
      rd_mux = {15'h0, phase1_ff};
    end else if (rd_is_inten) begin
      rd_mux = {24'h0, inten_ff[rd_idx[2:0]]};
    end else if (rd_idx == LPBI_IDX_STATUS) begin
      rd_mux = status_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign S_AXI_ARREADY_O = rd_idle;
  assign S_AXI_RVALID_O = (rd_state_ff == LPBI_RD_DATA);
  assign S_AXI_RDATA_O = rdata_ff;
  assign S_AXI_RRESP_O = rresp_ff;
  assign nxt_rd_state = ar_take ? LPBI_RD_DATA :
                        ((S_AXI_RVALID_O && S_AXI_RREADY_I) ? LPBI_RD_IDLE : rd_state_ff);

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_state_ff <= LPBI_RD_IDLE;
      rdata_ff <= 32'h0;
      rresp_ff <= LPBI_RESP_OKAY;
    end else begin
      rd_state_ff <= nxt_rd_state;
      if (ar_take) begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? LPBI_RESP_OKAY : LPBI_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // Oscillator and output stage
  // ----------------------------------------
  lpbi_slot_gen u_slot_gen (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .run_i(osc_run),
    .tick_o(tick)
  );

  logic [3:0] setting [LPBI_NUM_OUT];
  logic [LPBI_NUM_OUT-1:0] phase_bit;
  logic [LPBI_NUM_OUT-1:0] nxt_low;
  logic [LPBI_NUM_OUT-1:0] low_ff;

  // Global mode cannot spare individual ports; mix needs individual mode
  for (genvar i = 0; i < LPBI_NUM_OUT; i++) begin : g_out
    if (i == LPBI_NUM_OUT - 1) begin : g_aux
      assign setting[i] = lvl.aux;
    end else begin : g_port
      wire [3:0] own = pick_nibble(inten_ff[i/2], (i % 2) == 1);
      assign setting[i] = lvl.global_en ? lvl.aux : own;
    end
    assign phase_bit[i] = blink_sync_ff ? phase1_ff[i] : phase0_ff[i];
    // Complementary slot windows give the blink swap and the 0x7 balance
    assign nxt_low[i] = drive_low(setting[i], phase_bit[i], tick, lvl.master,
                                  osc_run);
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      low_ff <= '0;
    end else begin
      low_ff <= nxt_low;
    end
  end

  assign PORT_OUT_O = '0;
  assign PORT_OE_N_O = ~low_ff;

endmodule
`default_nettype wire

/* File: test/lpbi_led_load.sv */
// Purpose: LED loads with pull-ups on the open-drain outputs
// Assumes: Every pin has a pull-up to the high level
// Notes:   A released pin reads high, never the last driven value
`timescale 1ns/1ps
`default_nettype none
module lpbi_led_load
  import lpbi_pkg::*;
(
  input wire logic [lpbi_pkg::LPBI_NUM_OUT-1:0] oe_n_i,
  input wire logic [lpbi_pkg::LPBI_NUM_OUT-1:0] out_i,
  output logic [lpbi_pkg::LPBI_NUM_OUT-1:0] pin_o
);
  // Pull-up wins whenever the pin is released
  assign pin_o = oe_n_i | out_i;
endmodule
`default_nettype wire

/* File: test/lpbi_top_checker.sv */
// Purpose: Port-level assertions for lpbi_top
// Assumes: Address and data are offered together, all strobes set
// Notes:   Keeps its own copy of the level register
`timescale 1ns/1ps
`default_nettype none
module lpbi_top_checker
  import lpbi_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic BLINK_PHASE_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [lpbi_pkg::LPBI_AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [lpbi_pkg::LPBI_AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [lpbi_pkg::LPBI_NUM_OUT-1:0] PORT_OUT_O,
  input wire logic [lpbi_pkg::LPBI_NUM_OUT-1:0] PORT_OE_N_O
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam logic [7:0] lvl_a = {LPBI_IDX_LEVEL, 2'b00};
  logic wr_take;
  logic [7:0] lvl_ff;
  logic [7:0] nxt_lvl;
  logic [7:0] quiet_ff;
  logic [7:0] nxt_quiet;
  logic blink_ff;
  assign wr_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign nxt_lvl = (wr_take && S_AXI_AWADDR_I == lvl_a) ? S_AXI_WDATA_I[7:0] : lvl_ff;
  // Any write or blink edge may move the pins, so the quiet count restarts
  assign nxt_quiet = (wr_take || S_AXI_BVALID_O || BLINK_PHASE_I != blink_ff) ? 8'h00 :
                     quiet_ff + {7'h00, quiet_ff != 8'hff};
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lvl_ff <= 8'h00;
      quiet_ff <= 8'h00;
      blink_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl;
      quiet_ff <= nxt_quiet;
      blink_ff <= BLINK_PHASE_I;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_b_lat;
    wr_take |-> !S_AXI_BVALID_O ##2 S_AXI_BVALID_O;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_lat;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_lvl;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == lvl_a |=>
      S_AXI_RDATA_O == {24'h000000, lvl_ff};
  endproperty
  a_lvl: assert property (p_lvl) else $error("level readback differs");
  property p_od;
    PORT_OUT_O == '0;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_off;
    quiet_ff >= 8'h08 && lvl_ff[7:4] == LPBI_MASTER_OFF |-> $stable(PORT_OE_N_O);
  endproperty
  a_off: assert property (p_off) else $error("pins toggle with master off");
  property p_period;
    quiet_ff == 8'hff |-> PORT_OE_N_O == $past(PORT_OE_N_O, 240);
  endproperty
  a_period: assert property (p_period) else $error("pwm period not 240");
endmodule
bind lpbi_top lpbi_top_checker u_chk (
  .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .BLINK_PHASE_I(BLINK_PHASE_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .PORT_OUT_O(PORT_OUT_O), .PORT_OE_N_O(PORT_OE_N_O));
`default_nettype wire

/* File: test/led_pwm_blink_intensity_tb_top.sv */
// Purpose: Self-checking bench for lpbi_top
// Assumes: One write or one read at a time, all strobes set
// Notes:   Low time is counted over one full 240-cycle period
`timescale 1ns/1ps
`default_nettype none
module led_pwm_blink_intensity_tb_top;
  import lpbi_pkg::*;
  localparam logic [7:0] lvl_a = {LPBI_IDX_LEVEL, 2'b00};
  localparam logic [7:0] int_a = {LPBI_IDX_INTEN0, 2'b00};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic blink = 1'b0;
  logic aw_v = 1'b0;
  logic w_v = 1'b0;
  logic b_r = 1'b0;
  logic ar_v = 1'b0;
  logic r_r = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic [7:0] ar_a = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
  logic [1:0] b_rsp, r_rsp;
  logic [31:0] r_dat;
  logic [LPBI_NUM_OUT-1:0] p_out, p_oen, pin;
  int error_cnt = 0;
  int n_checks = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  always #5 clk = ~clk;
  lpbi_top u_dut (.CORE_CLK_I(clk), .NRST_I(nrst), .BLINK_PHASE_I(blink),
    .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_AWADDR_I(aw_a),
    .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy),
    .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(b_vld),
    .S_AXI_BREADY_I(b_r), .S_AXI_BRESP_O(b_rsp), .S_AXI_ARVALID_I(ar_v),
    .S_AXI_ARREADY_O(ar_rdy), .S_AXI_ARADDR_I(ar_a), .S_AXI_ARPROT_I(3'h0),
    .S_AXI_RVALID_O(r_vld), .S_AXI_RREADY_I(r_r), .S_AXI_RDATA_O(r_dat),
    .S_AXI_RRESP_O(r_rsp), .PORT_OUT_O(p_out), .PORT_OE_N_O(p_oen));
  lpbi_led_load u_load (.oe_n_i(p_oen), .out_i(p_out), .pin_o(pin));
  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("wrong value at %0t: no answer", $time);
    print_verdict();
  endtask
  // Answers are matched to the oldest note of the driver
  always @(posedge clk) begin
    if (b_vld && b_r) chk({32'h0, b_rsp}, {32'h0, bq.pop_front()}, "bresp");
    if (r_vld && r_r) chk({r_rsp, r_dat}, rq.pop_front(), "read");
  end
  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    int dly;
    done = 0;
    dly = $urandom() % 4;
    @(posedge clk);
    bq.push_back(er);
    aw_v <= 1'b1;
    w_v <= 1'b1;
    aw_a <= a;
    w_d <= d;
    for (int t = 0; t < 64 && !done; t++) begin
      @(posedge clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      // Late bready makes the slave hold its answer
      if (b_vld && b_r) begin
        b_r <= 1'b0;
        done = 1;
      end else if (t >= dly) begin
        b_r <= 1'b1;
      end
    end
    if (!done) tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    bit done;
    int dly;
    done = 0;
    dly = $urandom() % 4;
    @(posedge clk);
    rq.push_back(e);
    ar_v <= 1'b1;
    ar_a <= a;
    for (int t = 0; t < 64 && !done; t++) begin
      @(posedge clk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if (r_vld && r_r) begin
        r_r <= 1'b0;
        done = 1;
      end else if (t >= dly) begin
        r_r <= 1'b1;
      end
    end
    if (!done) tmo();
  endtask
  function automatic logic [33:0] lowcnt(input int n, input int m, input logic ph);
    if (n == 15) return ph ? 34'h0 : 34'h0f0;
    return ph ? 34'((15 - n) * m) : 34'((n + 1) * m);
  endfunction
  // Pins 0 and 16 follow the blink input, pin 1 has its phase bits swapped
  task automatic meas(input int n, input int m, input logic ph);
    int c0, c1, c16;
    c0 = 0;
    c1 = 0;
    c16 = 0;
    blink <= ph;
    repeat (8) @(posedge clk);
    repeat (240) begin
      @(posedge clk);
      c0 += !pin[0];
      c1 += !pin[1];
      c16 += !pin[16];
    end
    chk(34'(c0), lowcnt(n, m, ph), "low time pin0");
    chk(34'(c1), lowcnt(n, m, !ph), "low time pin1");
    chk(34'(c16), lowcnt(n, m, ph), "low time pin16");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    int m;
    v = $urandom(54897);
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    axi_rd(lvl_a, {LPBI_RESP_OKAY, 24'h0, LPBI_LEVEL_RST});
    axi_rd({LPBI_IDX_STATUS, 2'b00}, {LPBI_RESP_OKAY, 32'h0});
    axi_rd(8'hf0, {LPBI_RESP_SLVERR, 32'h0});
    axi_wr(8'hf4, 32'h1, LPBI_RESP_SLVERR);
    axi_wr({LPBI_IDX_STATUS, 2'b00}, 32'h0, LPBI_RESP_SLVERR);
    repeat (4) begin
      v = $urandom();
      axi_wr(lvl_a, v, LPBI_RESP_OKAY);
      axi_rd(lvl_a, {LPBI_RESP_OKAY, 24'h0, v[7:0]});
    end
    axi_wr({LPBI_IDX_PHASE0, 2'b00}, 32'h00002, LPBI_RESP_OKAY);
    axi_wr({LPBI_IDX_PHASE1, 2'b00}, 32'h10001, LPBI_RESP_OKAY);
    axi_rd({LPBI_IDX_PHASE1, 2'b00}, {LPBI_RESP_OKAY, 32'h10001});
    for (int n = 0; n < 16; n++) begin
      m = (n < 2) ? 15 - 14 * n : 1 + ($urandom() % 15);
      axi_wr(int_a, {24'h0, n[3:0], n[3:0]}, LPBI_RESP_OKAY);
      axi_wr(lvl_a, {24'h0, m[3:0], n[3:0]}, LPBI_RESP_OKAY);
      meas(n, m, 1'b0);
      meas(n, m, 1'b1);
    end
    // Global mode must override the per-pin setting of zero
    axi_wr({LPBI_IDX_CONFIG, 2'b00}, 32'h1, LPBI_RESP_OKAY);
    axi_wr(int_a, 32'h0, LPBI_RESP_OKAY);
    axi_wr(lvl_a, 32'hc9, LPBI_RESP_OKAY);
    meas(9, 12, 1'b0);
    // Quiet long enough for the period assertion to look back
    repeat (20) @(posedge clk);
    axi_wr(lvl_a, 32'h05, LPBI_RESP_OKAY);
    meas(5, 0, 1'b0);
    axi_wr(lvl_a, 32'h0f, LPBI_RESP_OKAY);
    meas(15, 0, 1'b1);
    axi_rd({LPBI_IDX_STATUS, 2'b00}, {LPBI_RESP_OKAY, 32'h40});
    print_verdict();
  end
endmodule
`default_nettype wire
